// file: logic/analog_mux_hall_wake_pkg.sv
// Constants, register layout and mode types of the analog mux, hall and wake control block
package analog_mux_hall_wake_pkg;
	// Register addresses
	localparam logic [7:0] HALL_WAKE_ADDR = 8'h07;
	localparam logic [7:0] ANALOG_MUX_ADDR = 8'h08;
	localparam logic [7:0] REG_RESET = 8'h00;
	// input_mux_control field positions
	localparam int CURRENT_SOURCE_ON_BIT = 7;
	localparam int LEVEL_HI = 6;
	localparam int LEVEL_LO = 5;
	localparam int GAIN_BIT = 4;
	localparam int SEL_HI = 3;
	localparam int SEL_LO = 0;
	// hall_wake_status_control field positions
	localparam int HMODE_BIT = 0;
	localparam int HEN_BIT = 1;
	localparam int HPD_BIT = 2;
	localparam int HFLAG_BIT = 3;
	localparam int HOC_BIT = 4;
	localparam int WSTATE_BIT = 5;
	// Source codes
	localparam logic [3:0] SRC_HS_LAST = 4'h6;
	localparam logic [3:0] SRC_UNUSED = 4'h7;
	localparam logic [3:0] SRC_TEMP = 4'h8;
	localparam logic [3:0] SRC_EC = 4'hC;
	localparam int NUM_SOURCES = 12;
	// Time software waits before sampling the hall flag, in us, and cycles at 25 MHz
	localparam int HALL_SETTLE_US = 40;
	localparam int CLOCK_MHZ = 25;
	localparam int HALL_SETTLE_CYCLES = HALL_SETTLE_US * CLOCK_MHZ;
	// Power modes of the surrounding device
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_STOP,
		MODE_SLEEP
	} power_mode_e;
endpackage

// file: logic/analog_mux_hall_wake_control.sv
// Control and status logic for analog source selection, hall input and wake input
`timescale 1ns/1ps
module analog_mux_hall_wake_control #(
	parameter int SOURCES = analog_mux_hall_wake_pkg::NUM_SOURCES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire analog_mux_hall_wake_pkg::power_mode_e power_mode,
	input wire logic hall_input_pin,
	input wire logic hall_current_low,
	input wire logic hall_overcurrent,
	input wire logic wake_input_pin,
	input wire logic hall_interrupt_mask,
	input wire logic hall_irq_clear,
	input wire logic wake_input_irq_enable,
	input wire logic wake_irq_clear,
	input wire logic wakeup_flag_clear,
	output logic [11:0] analog_source_on,
	output logic current_source_enable,
	output logic [1:0] current_level,
	output logic sense_gain_low,
	output logic hall_supply_on,
	output logic hall_sense_on,
	output logic hall_pullup_on,
	output logic hall_interrupt_flag,
	output logic hall_irq,
	output logic wake_irq_flag,
	output logic wake_irq,
	output logic wake_pin_wakeup_flag,
	output logic wake_request
);
	import analog_mux_hall_wake_pkg::*;

	// Refuse a source count that the decoder cannot serve
	generate
		if (SOURCES != NUM_SOURCES) begin : g_bad_sources
			$error("analog source count must be twelve");
		end
	endgenerate

	// Map a source code to a one-hot switch set, none for unused codes
	function automatic logic [11:0] decode_source(input logic [3:0] code);
		logic [11:0] hot;
		hot = 12'h000;
		if (code <= SRC_HS_LAST) begin
			hot[code] = 1'b1;
		end else if (code >= SRC_TEMP && code <= SRC_EC) begin
			hot[4'(code - 4'h1)] = 1'b1;
		end
		return hot;
	endfunction

	// Register state
	logic [7:0] mux_ctrl_ff;
	logic hall_mode_ff;
	logic hall_enable_ff;
	logic hall_pd_ff;
	logic hall_oc_flag_ff;
	logic [7:0] rdata_ff;
	// Pin synchronisers
	logic hall_pin_meta_ff;
	logic hall_pin_ff;
	logic hall_cur_meta_ff;
	logic hall_cur_ff;
	logic hall_oc_meta_ff;
	logic hall_oc_ff;
	logic wake_meta_ff;
	logic wake_ff;
	// Event tracking
	logic hall_prev_ff;
	logic wake_prev_ff;
	logic hall_int_ff;
	logic hall_irq_ff;
	logic wake_int_ff;
	logic wake_irq_ff;
	logic wake_latched_ff;
	logic low_power_prev_ff;
	logic wake_fired_ff;
	logic wakeup_ff;
	logic wake_req_ff;
	// Output flops
	logic [11:0] source_ff;
	logic cs_en_ff;
	logic [1:0] level_ff;
	logic gain_ff;
	logic supply_ff;
	logic sense_ff;
	logic pullup_ff;

	// Combinational helpers
	logic wr_mux;
	logic wr_hall;
	logic in_run;
	logic low_power;
	logic hall_state;
	logic hall_change;
	logic wake_change;
	logic wake_mismatch;

	assign wr_mux = reg_wr && (reg_addr == ANALOG_MUX_ADDR);
	assign wr_hall = reg_wr && (reg_addr == HALL_WAKE_ADDR);
	assign in_run = (power_mode == MODE_RUN);
	assign low_power = (power_mode == MODE_STOP) || (power_mode == MODE_SLEEP);

	// Hall flag follows pin in general purpose mode, current sense in hall mode
	assign hall_state = hall_mode_ff ? hall_cur_ff : hall_pin_ff;
	assign hall_change = hall_state != hall_prev_ff;
	assign wake_change = wake_ff != wake_prev_ff;
	assign wake_mismatch = wake_ff != wake_latched_ff;

	// Two-stage synchronisers; the hall pin starts high, its pulled-up idle level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hall_pin_meta_ff <= 1'b1;
			hall_pin_ff <= 1'b1;
			hall_cur_meta_ff <= 1'b0;
			hall_cur_ff <= 1'b0;
			hall_oc_meta_ff <= 1'b0;
			hall_oc_ff <= 1'b0;
			wake_meta_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			hall_pin_meta_ff <= hall_input_pin;
			hall_pin_ff <= hall_pin_meta_ff;
			hall_cur_meta_ff <= hall_current_low;
			hall_cur_ff <= hall_cur_meta_ff;
			hall_oc_meta_ff <= hall_overcurrent;
			hall_oc_ff <= hall_oc_meta_ff;
			wake_meta_ff <= wake_input_pin;
			wake_ff <= wake_meta_ff;
		end
	end

	// Analog mux control register, all fields reset to zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mux_ctrl_ff <= REG_RESET;
		end else if (wr_mux) begin
			mux_ctrl_ff <= reg_wdata;
		end
	end

	// Hall control bits; reset leaves general purpose mode with pull-up on
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hall_mode_ff <= 1'b0;
			hall_enable_ff <= 1'b0;
			hall_pd_ff <= 1'b0;
		end else if (wr_hall) begin
			hall_mode_ff <= reg_wdata[HMODE_BIT];
			hall_enable_ff <= reg_wdata[HEN_BIT];
			hall_pd_ff <= reg_wdata[HPD_BIT];
		end
	end

	// Sticky overcurrent flag, a new event wins over a write-one clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hall_oc_flag_ff <= 1'b0;
		end else if (hall_oc_ff && hall_mode_ff) begin
			hall_oc_flag_ff <= 1'b1;
		end else if (wr_hall && reg_wdata[HOC_BIT]) begin
			hall_oc_flag_ff <= 1'b0;
		end
	end

	// Registered read of the addressed register, unmapped reads zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_ff <= REG_RESET;
		end else if (reg_addr == ANALOG_MUX_ADDR) begin
			rdata_ff <= mux_ctrl_ff;
		end else if (reg_addr == HALL_WAKE_ADDR) begin
			rdata_ff <= REG_RESET;
			rdata_ff[HMODE_BIT] <= hall_mode_ff;
			rdata_ff[HEN_BIT] <= hall_enable_ff;
			rdata_ff[HPD_BIT] <= hall_pd_ff;
			rdata_ff[HFLAG_BIT] <= hall_state;
			rdata_ff[HOC_BIT] <= hall_oc_flag_ff;
			rdata_ff[WSTATE_BIT] <= wake_ff;
		end else begin
			rdata_ff <= REG_RESET;
		end
	end

	// Analog source switches and current source controls
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			source_ff <= 12'h001;
			cs_en_ff <= 1'b0;
			level_ff <= 2'b00;
			gain_ff <= 1'b0;
		end else begin
			source_ff <= decode_source(mux_ctrl_ff[SEL_HI:SEL_LO]);
			cs_en_ff <= mux_ctrl_ff[CURRENT_SOURCE_ON_BIT];
			level_ff <= mux_ctrl_ff[LEVEL_HI:LEVEL_LO];
			gain_ff <= mux_ctrl_ff[GAIN_BIT];
		end
	end

	// Hall pin supply, sensing and pull-up drive
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			supply_ff <= 1'b0;
			sense_ff <= 1'b0;
			pullup_ff <= 1'b1;
		end else begin
			supply_ff <= hall_mode_ff && hall_enable_ff;
			sense_ff <= hall_mode_ff && hall_enable_ff;
			pullup_ff <= !hall_pd_ff;
		end
	end

	// Previous levels for edge detection; hall starts at its idle high, so reset makes no false edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hall_prev_ff <= 1'b1;
			wake_prev_ff <= 1'b0;
		end else begin
			hall_prev_ff <= hall_state;
			wake_prev_ff <= wake_ff;
		end
	end

	// Hall interrupt flag on any change in RUN, set wins over clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hall_int_ff <= 1'b0;
			hall_irq_ff <= 1'b0;
		end else begin
			if (in_run && hall_change) begin
				hall_int_ff <= 1'b1;
			end else if (hall_irq_clear) begin
				hall_int_ff <= 1'b0;
			end
			hall_irq_ff <= hall_int_ff && hall_interrupt_mask;
		end
	end

	// Wake interrupt on both edges in RUN, set wins over clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_int_ff <= 1'b0;
			wake_irq_ff <= 1'b0;
		end else begin
			if (in_run && wake_change) begin
				wake_int_ff <= 1'b1;
			end else if (wake_irq_clear) begin
				wake_int_ff <= 1'b0;
			end
			wake_irq_ff <= wake_int_ff && wake_input_irq_enable;
		end
	end

	// Latch wake level on entry to a low-power mode
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			low_power_prev_ff <= 1'b0;
			wake_latched_ff <= 1'b0;
		end else begin
			low_power_prev_ff <= low_power;
			if (low_power && !low_power_prev_ff) begin
				wake_latched_ff <= wake_ff;
			end
		end
	end

	// One wake-up request per low-power stay when the level differs
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_fired_ff <= 1'b0;
			wake_req_ff <= 1'b0;
		end else begin
			wake_req_ff <= 1'b0;
			if (!low_power) begin
				wake_fired_ff <= 1'b0;
			end else if (low_power_prev_ff && wake_mismatch && !wake_fired_ff) begin
				wake_fired_ff <= 1'b1;
				wake_req_ff <= 1'b1;
			end
		end
	end

	// Reset status wake-up flag, set wins over clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wakeup_ff <= 1'b0;
		end else if (wake_req_ff) begin
			wakeup_ff <= 1'b1;
		end else if (wakeup_flag_clear) begin
			wakeup_ff <= 1'b0;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = rdata_ff;
	assign analog_source_on = source_ff;
	assign current_source_enable = cs_en_ff;
	assign current_level = level_ff;
	assign sense_gain_low = gain_ff;
	assign hall_supply_on = supply_ff;
	assign hall_sense_on = sense_ff;
	assign hall_pullup_on = pullup_ff;
	assign hall_interrupt_flag = hall_int_ff;
	assign hall_irq = hall_irq_ff;
	assign wake_irq_flag = wake_int_ff;
	assign wake_irq = wake_irq_ff;
	assign wake_pin_wakeup_flag = wakeup_ff;
	assign wake_request = wake_req_ff;
endmodule

// file: testbench/mcu_core_model.sv
// Register-bus side of the embedded core
`timescale 1ns/1ps
module mcu_core_model (
	input wire logic clock,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	import analog_mux_hall_wake_pkg::*;
	// Bus idle at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	// Write taken at the edge after the request is raised
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~d; // Stale data is not left on the bus
	endtask
	// Read data is registered one edge after the address stands
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		@(negedge clock);
		d = reg_rdata;
	endtask
	// Sensor settling time after sensing is switched on
	task settle();
		repeat (HALL_SETTLE_CYCLES) @(posedge clock);
	endtask
endmodule

// file: testbench/analog_mux_hall_wake_properties.sv
// Port checks for the analog mux, hall and wake control block
`timescale 1ns/1ps
module analog_mux_hall_wake_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire analog_mux_hall_wake_pkg::power_mode_e power_mode,
	input wire logic hall_interrupt_mask,
	input wire logic [11:0] analog_source_on,
	input wire logic current_source_enable,
	input wire logic [1:0] current_level,
	input wire logic hall_pullup_on,
	input wire logic hall_irq,
	input wire logic wake_pin_wakeup_flag,
	input wire logic wake_request
);
	import analog_mux_hall_wake_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Writes to each register
	wire mux_wr = reg_wr && reg_addr == ANALOG_MUX_ADDR;
	wire hw_wr = reg_wr && reg_addr == HALL_WAKE_ADDR;
	// Switch pattern per code; unused codes switch nothing
	function automatic logic [11:0] dec(input logic [7:0] w);
		if (w[3:0] <= SRC_HS_LAST) return 12'h001 << w[3:0];
		if (w[3:0] >= SRC_TEMP && w[3:0] <= SRC_EC) return 12'h001 << (w[3:0] - 4'h1);
		return 12'h000;
	endfunction
	property p_one; $onehot0(analog_source_on); endproperty
	a_one: assert property (p_one) else $error("two sources on");
	property p_src; mux_wr |-> ##2 analog_source_on == dec($past(reg_wdata, 2)); endproperty
	a_src: assert property (p_src) else $error("wrong source");
	property p_current_source_on; mux_wr |-> ##2 current_source_enable == $past(reg_wdata[7], 2); endproperty
	a_current_source_on: assert property (p_current_source_on) else $error("current source enable wrong");
	property p_lvl; mux_wr |-> ##2 current_level == $past(reg_wdata[6:5], 2); endproperty
	a_lvl: assert property (p_lvl) else $error("current level wrong");
	property p_pu; hw_wr |-> ##2 hall_pullup_on == !$past(reg_wdata[2], 2); endproperty
	a_pu: assert property (p_pu) else $error("pull-up wrong");
	property p_hirq; $rose(hall_irq) |-> $past(hall_interrupt_mask); endproperty
	a_hirq: assert property (p_hirq) else $error("hall irq while masked");
	property p_wreq; wake_request |-> $past(power_mode) != MODE_RUN ##1 !wake_request; endproperty
	a_wreq: assert property (p_wreq) else $error("bad wake request");
	property p_wflag; wake_request |=> wake_pin_wakeup_flag; endproperty
	a_wflag: assert property (p_wflag) else $error("wake flag not set");
	c_unused: cover property (mux_wr ##2 analog_source_on == 12'h000);
	c_hirq: cover property (hall_irq);
	c_wake: cover property (wake_request);
endmodule
bind analog_mux_hall_wake_control analog_mux_hall_wake_checker chk (.clock, .rst, .reg_addr, .reg_wr,
	.reg_wdata, .power_mode, .hall_interrupt_mask, .analog_source_on, .current_source_enable,
	.current_level, .hall_pullup_on, .hall_irq, .wake_pin_wakeup_flag, .wake_request);

// file: testbench/analog_mux_hall_wake_control_test.sv
// Self-checking bench for the analog mux, hall and wake control block
`timescale 1ns/1ps
module analog_mux_hall_wake_control_test;
	import analog_mux_hall_wake_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	power_mode_e power_mode = MODE_RUN;
	// Hall pin idles high through its pull-up
	logic hall_input_pin = 1'b1, hall_current_low = 1'b0, hall_overcurrent = 1'b0, wake_input_pin = 1'b0;
	logic hall_interrupt_mask = 1'b1, hall_irq_clear = 1'b0, wake_input_irq_enable = 1'b0;
	logic wake_irq_clear = 1'b0, wakeup_flag_clear = 1'b0, reg_wr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [11:0] analog_source_on;
	logic [1:0] current_level;
	logic current_source_enable, sense_gain_low, hall_supply_on, hall_sense_on, hall_pullup_on;
	logic hall_interrupt_flag, hall_irq, wake_irq_flag, wake_irq, wake_pin_wakeup_flag, wake_request;
	int failures = 0, cmp_count = 0, cycles = 0, wreqs = 0;
	analog_mux_hall_wake_control uut (.clock, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .power_mode,
		.hall_input_pin, .hall_current_low, .hall_overcurrent, .wake_input_pin, .hall_interrupt_mask,
		.hall_irq_clear, .wake_input_irq_enable, .wake_irq_clear, .wakeup_flag_clear, .analog_source_on,
		.current_source_enable, .current_level, .sense_gain_low, .hall_supply_on, .hall_sense_on,
		.hall_pullup_on, .hall_interrupt_flag, .hall_irq, .wake_irq_flag, .wake_irq, .wake_pin_wakeup_flag,
		.wake_request);
	mcu_core_model core (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata);
	// Clock
	initial forever #20 clock = ~clock;
	// Wake pulse count and hang limit
	always @(posedge clock) begin
		cycles++;
		if (wake_request) wreqs++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	task chk(input logic [11:0] g, input logic [11:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		core.rd(a, rv);
		chk(rv & m, e);
	endtask
	// Pins change together, then the synchronisers settle
	task drive(input logic hp, input logic cl, input logic oc, input logic wp);
		@(posedge clock);
		hall_input_pin <= hp;
		hall_current_low <= cl;
		hall_overcurrent <= oc;
		wake_input_pin <= wp;
		repeat (6) @(posedge clock);
	endtask
	task clr();
		@(posedge clock);
		{hall_irq_clear, wake_irq_clear, wakeup_flag_clear} <= 3'b111;
		@(posedge clock);
		{hall_irq_clear, wake_irq_clear, wakeup_flag_clear} <= 3'b000;
	endtask
	function automatic logic [11:0] exp_src(input logic [3:0] c);
		if (c < 4'h7) return 12'h001 << c;
		if (c > 4'h7 && c < 4'hD) return 12'h001 << (c - 4'h1);
		return 12'h000;
	endfunction
	task t_reset();
		rdc(8'h08, 8'hFF, 8'h00);
		rdc(8'h07, 8'h3F, 8'h08);
		chk(analog_source_on, 12'h001);
		chk(hall_pullup_on, 1'b1);
		chk({hall_interrupt_flag, wake_irq_flag}, 2'b00);
		chk({current_source_enable, current_level, sense_gain_low}, 4'h0);
		$display("reset done");
	endtask
	task t_mux();
		logic [7:0] d;
		for (int c = 0; c < 16; c++) begin
			d = {c[0], c[2:1], c[3], c[3:0]};
			core.wr(ANALOG_MUX_ADDR, d);
			rdc(ANALOG_MUX_ADDR, 8'hFF, d);
			chk(analog_source_on, exp_src(c[3:0]));
			chk({current_source_enable, current_level, sense_gain_low}, d[7:4]);
		end
		core.wr(8'h09, 8'h5A);
		rdc(8'h09, 8'hFF, 8'h00);
		rdc(ANALOG_MUX_ADDR, 8'hFF, d);
		$display("mux done");
	endtask
	task t_hall();
		core.wr(HALL_WAKE_ADDR, 8'h03);
		core.settle();
		chk({hall_supply_on, hall_sense_on, hall_pullup_on}, 3'b111);
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		rdc(HALL_WAKE_ADDR, 8'h08, 8'h08);
		chk({hall_interrupt_flag, hall_irq}, 2'b11);
		@(posedge clock);
		hall_interrupt_mask <= 1'b0;
		clr();
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		rdc(HALL_WAKE_ADDR, 8'h08, 8'h00);
		chk({hall_interrupt_flag, hall_irq}, 2'b10);
		core.wr(HALL_WAKE_ADDR, 8'h04);
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		rdc(HALL_WAKE_ADDR, 8'h0F, 8'h04);
		chk({hall_supply_on, hall_pullup_on}, 2'b00);
		@(posedge clock);
		power_mode <= MODE_STOP;
		clr();
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		chk(hall_interrupt_flag, 1'b0);
		power_mode <= MODE_RUN;
		$display("hall done");
	endtask
	task t_oc();
		core.wr(HALL_WAKE_ADDR, 8'h01);
		drive(1'b0, 1'b1, 1'b1, 1'b0);
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		rdc(HALL_WAKE_ADDR, 8'h10, 8'h10);
		core.wr(HALL_WAKE_ADDR, 8'h01);
		rdc(HALL_WAKE_ADDR, 8'h10, 8'h10);
		core.wr(HALL_WAKE_ADDR, 8'h11);
		rdc(HALL_WAKE_ADDR, 8'h10, 8'h00);
		core.wr(HALL_WAKE_ADDR, 8'h00);
		drive(1'b0, 1'b1, 1'b1, 1'b0);
		rdc(HALL_WAKE_ADDR, 8'h10, 8'h00);
		$display("overcurrent done");
	endtask
	task t_wake();
		int b;
		clr();
		drive(1'b0, 1'b1, 1'b0, 1'b1);
		rdc(HALL_WAKE_ADDR, 8'h20, 8'h20);
		chk({wake_irq_flag, wake_irq}, 2'b10);
		@(posedge clock);
		wake_input_irq_enable <= 1'b1;
		clr();
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		chk({wake_irq_flag, wake_irq}, 2'b11);
		rdc(HALL_WAKE_ADDR, 8'h20, 8'h00);
		@(posedge clock);
		power_mode <= MODE_SLEEP;
		b = wreqs;
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		chk(12'(wreqs - b), 12'h000);
		drive(1'b0, 1'b1, 1'b0, 1'b1);
		chk(12'(wreqs - b), 12'h001);
		chk(wake_pin_wakeup_flag, 1'b1);
		power_mode <= MODE_RUN;
		clr();
		@(negedge clock);
		chk(wake_pin_wakeup_flag, 1'b0);
		// Falling wake level during STOP also wakes once
		@(posedge clock);
		power_mode <= MODE_STOP;
		b = wreqs;
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		chk(12'(wreqs - b), 12'h001);
		chk(wake_pin_wakeup_flag, 1'b1);
		power_mode <= MODE_RUN;
		$display("wake done");
	endtask
	task print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_mux();
		t_hall();
		t_oc();
		t_wake();
		print_verdict();
	end
endmodule
